// file: shared/pasp_pkg.sv
// Constants shared by the phase alarm and sync pulse configuration block
package pasp_pkg;

  // Register port widths
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;

  // Register addresses
  localparam logic [ADDR_W-1:0] ADDR_ALARM_DELAY = 7'h79;
  localparam logic [ADDR_W-1:0] ADDR_SYNC_CFG = 7'h7a;

  // Reset values
  localparam logic [DATA_W-1:0] ALARM_DELAY_RESET = 8'h32;
  localparam logic [DATA_W-1:0] SYNC_CFG_RESET = 8'h00;

  // Writable bits; the unused bits read as zero
  localparam logic [DATA_W-1:0] ALARM_DELAY_MASK = 8'h3f;
  localparam logic [DATA_W-1:0] SYNC_CFG_MASK = 8'h8f;

  // Alarm delay field, top bit
  localparam int ALARM_FIELD_MSB = 5;

  // Sync configuration bit positions
  localparam int SYNC_SOURCE_SELECT_BIT = 7;
  localparam int FRAME_SYNC_POLARITY_BIT = 3;
  localparam int FRAME_SYNC_SHAPE_BIT = 2;
  localparam int MULTIFRAME_SYNC_POLARITY_BIT = 1;
  localparam int MULTIFRAME_SYNC_SHAPE_BIT = 0;

  // Timing: one second in ns and the mclk period in ns
  localparam longint ONE_SECOND_NS = 1000000000;
  localparam longint MCLK_PERIOD_NS = 50;
  localparam int SEC_CYCLES = int'(ONE_SECOND_NS / MCLK_PERIOD_NS);
  localparam int CYC_CNT_W = 25;

  // Seconds counter width and the automatic alarm release time in seconds
  localparam int SEC_CNT_W = 8;
  localparam logic [SEC_CNT_W-1:0] ALARM_HOLD_SEC = 8'h80;
  localparam logic [SEC_CNT_W-1:0] ALARM_HOLD_LAST = 8'h7f;

  // Alarm timer states
  typedef enum logic [1:0] {
    ALM_IDLE,
    ALM_TIMING,
    ALM_RAISED
  } pasp_alarm_state_t;

endpackage : pasp_pkg

// file: logic/pasp_sync_shaper.sv
`timescale 1ns/1ps
// Shapes one sync output: 50:50 pass-through or one width-reference period
module pasp_sync_shaper (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Selected sync square wave and width reference
  input wire logic syncIn,
  input wire logic widthRef,
  // Configuration
  input wire logic pulseMode,
  input wire logic invert,
  // Shaped output
  output logic syncOut
);
  import pasp_pkg::*;

  // All state of the shaper
  typedef struct packed {
    logic syncPrev; // Previous sync level
    logic refPrev; // Previous width reference level
    logic armed; // Sync edge seen, waiting for reference edge
    logic pulsing; // Pulse currently open
    logic out; // Registered output
  } pasp_shaper_state_t;

  pasp_shaper_state_t s_reg;
  pasp_shaper_state_t s_next;
  logic syncRise; // Rising edge of sync input
  logic refRise; // Rising edge of width reference

  assign syncRise = syncIn & ~s_reg.syncPrev;
  assign refRise = widthRef & ~s_reg.refPrev;

  // Next state: edge tracking, pulse window and polarity
  always_comb
  begin
    s_next = s_reg;
    s_next.syncPrev = syncIn;
    s_next.refPrev = widthRef;
    if (!pulseMode)
    begin
      // 50:50 mode keeps no pulse state
      s_next.armed = 1'b0;
      s_next.pulsing = 1'b0;
    end
    else
    begin
      // Pulse closes on the next reference edge, one period wide
      if (s_reg.pulsing && refRise)
      begin
        s_next.pulsing = 1'b0;
      end
      // Pulse opens on the first reference edge after a sync edge
      if (s_reg.armed && refRise)
      begin
        s_next.armed = 1'b0;
        s_next.pulsing = 1'b1;
      end
      // New sync edge arms the next pulse
      if (syncRise)
      begin
        s_next.armed = 1'b1;
      end
    end
    // Shape then polarity
    s_next.out = (pulseMode ? s_next.pulsing : syncIn) ^ invert;
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign syncOut = s_reg.out;

  // Pulse run: open pulse with no closing edge
  sequence s_pulse_run;
    pulseMode && s_reg.pulsing && !refRise;
  endsequence

  // Pulse open: armed and reference edge arrives
  sequence s_pulse_open;
    pulseMode && s_reg.armed && refRise;
  endsequence

  property p_follow_plain;
    @(posedge mclk) disable iff (rst)
      !pulseMode |=> syncOut == ($past(syncIn) ^ $past(invert));
  endproperty
  a_follow_plain: assert property (p_follow_plain)
    else $error("plain sync output does not follow input and polarity");

  property p_pulse_opens;
    @(posedge mclk) disable iff (rst)
      s_pulse_open |=> s_reg.pulsing && (syncOut != $past(invert));
  endproperty
  a_pulse_opens: assert property (p_pulse_opens)
    else $error("pulse did not open on reference edge");

  property p_pulse_holds;
    @(posedge mclk) disable iff (rst)
      s_pulse_run ##1 pulseMode |-> s_reg.pulsing;
  endproperty
  a_pulse_holds: assert property (p_pulse_holds)
    else $error("pulse closed before a reference edge");

  property p_pulse_closes;
    @(posedge mclk) disable iff (rst)
      pulseMode && s_reg.pulsing && !s_reg.armed && refRise |=> !s_reg.pulsing;
  endproperty
  a_pulse_closes: assert property (p_pulse_closes)
    else $error("pulse wider than one reference period");

endmodule : pasp_sync_shaper

// file: logic/pasp_top.sv
`timescale 1ns/1ps
// Function
// - Rejected input stays rejected until alarmClear or the 128 s hold expires, no remeasure
// - Bit 7 picks main or auxiliary PLL
// - Bit 2 frame sync pulsed or 50:50
// - Bits 3 and 1 invert sync outputs
// - Bit 0 multiframe sync pulsed or 50:50
module pasp_top #(
  parameter int CYCLES_PER_SEC = pasp_pkg::SEC_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Microprocessor register port
  input wire logic [pasp_pkg::ADDR_W-1:0] regAddr,
  input wire logic [pasp_pkg::DATA_W-1:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [pasp_pkg::DATA_W-1:0] regRdData,
  // Controlling state machine interface
  input wire logic pllInPreLockOrLost,
  input wire logic alarmClear,
  output logic phaseAlarm,
  // Sync sources from both PLLs and the width reference output
  input wire logic mainFrameSync,
  input wire logic mainMultiframeSync,
  input wire logic auxFrameSync,
  input wire logic auxMultiframeSync,
  input wire logic widthReferenceOutput,
  // Shaped sync outputs
  output logic frameSyncOutput,
  output logic multiframeSyncOutput,
  // General clock output sync sources
  output logic genFrameSync,
  output logic genMultiframeSync
);
  import pasp_pkg::*;

  // Last cycle of a second
  localparam logic [CYC_CNT_W-1:0] SEC_LAST = CYC_CNT_W'(CYCLES_PER_SEC - 1);

  // All state of the block
  typedef struct packed {
    pasp_alarm_state_t alarmState; // Alarm timer state
    logic [CYC_CNT_W-1:0] cycCnt; // Cycles within the current second
    logic [SEC_CNT_W-1:0] secCnt; // Whole seconds counted
    logic phaseAlarm; // Alarm against selected input
    logic [DATA_W-1:0] alarmDelay; // Delay register
    logic [DATA_W-1:0] syncCfg; // Sync output register
    logic [DATA_W-1:0] rdData; // Read data
    logic genFrame; // Registered general frame sync
    logic genMultiframe; // Registered general multiframe sync
  } pasp_top_state_t;

  pasp_top_state_t s_reg;
  pasp_top_state_t s_next;
  logic secTick; // Last cycle of a second
  logic [SEC_CNT_W-1:0] alarmLimit; // Twice the delay field
  logic frameSel; // Frame sync from the chosen PLL
  logic multiframeSel; // Multiframe sync from the chosen PLL

  assign secTick = (s_reg.cycCnt == SEC_LAST);
  assign alarmLimit = {1'b0, s_reg.alarmDelay[ALARM_FIELD_MSB:0], 1'b0};

  // Sync source selection
  assign frameSel = s_reg.syncCfg[SYNC_SOURCE_SELECT_BIT] ? auxFrameSync
                                                          : mainFrameSync;
  assign multiframeSel = s_reg.syncCfg[SYNC_SOURCE_SELECT_BIT] ? auxMultiframeSync
                                                               : mainMultiframeSync;

  // Next state: register port and alarm timer
  always_comb
  begin
    s_next = s_reg;
    s_next.genFrame = frameSel;
    s_next.genMultiframe = multiframeSel;
    // Register writes, unused bits forced to zero
    if (regWrEn && regAddr == ADDR_ALARM_DELAY)
    begin
      s_next.alarmDelay = regWrData & ALARM_DELAY_MASK;
    end
    if (regWrEn && regAddr == ADDR_SYNC_CFG)
    begin
      s_next.syncCfg = regWrData & SYNC_CFG_MASK;
    end
    // Register reads, unmapped addresses read zero
    if (regRdEn)
    begin
      case (regAddr)
        ADDR_ALARM_DELAY: s_next.rdData = s_reg.alarmDelay;
        ADDR_SYNC_CFG: s_next.rdData = s_reg.syncCfg;
        default: s_next.rdData = '0;
      endcase
    end
    // Seconds counting while timing or holding the alarm
    if (s_reg.alarmState != ALM_IDLE)
    begin
      s_next.cycCnt = secTick ? '0 : s_reg.cycCnt + 1'b1;
      if (secTick)
      begin
        s_next.secCnt = s_reg.secCnt + 1'b1;
      end
    end
    // Alarm timer
    case (s_reg.alarmState)
      ALM_IDLE:
      begin
        // Start timing when the state machine enters pre-lock or phase-lost
        s_next.cycCnt = '0;
        s_next.secCnt = '0;
        if (pllInPreLockOrLost)
        begin
          s_next.alarmState = ALM_TIMING;
        end
      end
      ALM_TIMING:
      begin
        if (!pllInPreLockOrLost)
        begin
          // Left the watched states, stop measuring
          s_next.alarmState = ALM_IDLE;
          s_next.cycCnt = '0;
          s_next.secCnt = '0;
        end
        else if (s_reg.secCnt >= alarmLimit)
        begin
          // Delay expired, raise the alarm
          s_next.alarmState = ALM_RAISED;
          s_next.phaseAlarm = 1'b1;
          s_next.cycCnt = '0;
          s_next.secCnt = '0;
        end
      end
      ALM_RAISED:
      begin
        // Input is no longer selected, so no remeasure; held until release
        if (alarmClear || s_reg.secCnt == ALARM_HOLD_SEC)
        begin
          s_next.alarmState = ALM_IDLE;
          s_next.phaseAlarm = 1'b0;
          s_next.cycCnt = '0;
          s_next.secCnt = '0;
        end
      end
      default:
      begin
        s_next.alarmState = ALM_IDLE;
        s_next.phaseAlarm = 1'b0;
      end
    endcase
  end

  // State register
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_reg.alarmState <= ALM_IDLE;
      s_reg.cycCnt <= '0;
      s_reg.secCnt <= '0;
      s_reg.phaseAlarm <= 1'b0;
      s_reg.alarmDelay <= ALARM_DELAY_RESET;
      s_reg.syncCfg <= SYNC_CFG_RESET;
      s_reg.rdData <= '0;
      s_reg.genFrame <= 1'b0;
      s_reg.genMultiframe <= 1'b0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign regRdData = s_reg.rdData;
  assign phaseAlarm = s_reg.phaseAlarm;
  assign genFrameSync = s_reg.genFrame;
  assign genMultiframeSync = s_reg.genMultiframe;

  // Frame sync output shaper
  pasp_sync_shaper u_frame_shaper (
    .mclk(mclk),
    .rst(rst),
    .syncIn(frameSel),
    .widthRef(widthReferenceOutput),
    .pulseMode(s_reg.syncCfg[FRAME_SYNC_SHAPE_BIT]),
    .invert(s_reg.syncCfg[FRAME_SYNC_POLARITY_BIT]),
    .syncOut(frameSyncOutput)
  );

  // Multiframe sync output shaper
  pasp_sync_shaper u_multiframe_shaper (
    .mclk(mclk),
    .rst(rst),
    .syncIn(multiframeSel),
    .widthRef(widthReferenceOutput),
    .pulseMode(s_reg.syncCfg[MULTIFRAME_SYNC_SHAPE_BIT]),
    .invert(s_reg.syncCfg[MULTIFRAME_SYNC_POLARITY_BIT]),
    .syncOut(multiframeSyncOutput)
  );

  property p_alarm_after_delay;
    @(posedge mclk) disable iff (rst)
      $rose(phaseAlarm) |-> $past(s_reg.secCnt) >= $past(alarmLimit)
        && $past(pllInPreLockOrLost);
  endproperty
  a_alarm_after_delay: assert property (p_alarm_after_delay)
    else $error("phase alarm raised before the delay elapsed");

  property p_alarm_held;
    @(posedge mclk) disable iff (rst)
      phaseAlarm && !alarmClear && s_reg.secCnt < ALARM_HOLD_LAST |=> phaseAlarm
        && s_reg.alarmState == ALM_RAISED;
  endproperty
  a_alarm_held: assert property (p_alarm_held)
    else $error("phase alarm dropped without clear or hold expiry");

  property p_source_select;
    @(posedge mclk) disable iff (rst)
      ##1 genFrameSync == ($past(s_reg.syncCfg[SYNC_SOURCE_SELECT_BIT])
        ? $past(auxFrameSync) : $past(mainFrameSync));
  endproperty
  a_source_select: assert property (p_source_select)
    else $error("general frame sync taken from the wrong PLL");

  property p_cfg_write;
    @(posedge mclk) disable iff (rst)
      regWrEn && regAddr == ADDR_SYNC_CFG |=> s_reg.syncCfg == ($past(regWrData)
        & SYNC_CFG_MASK);
  endproperty
  a_cfg_write: assert property (p_cfg_write)
    else $error("sync configuration write not stored");

endmodule : pasp_top

// file: test/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the alarm timer and sync output configuration
module tb_top;
  import pasp_pkg::*;
  // Clock, reset and register port
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic regWrEn = 1'b0;
  logic regRdEn = 1'b0;
  logic [DATA_W-1:0] regRdData;
  // Alarm timer and sync sources
  logic pll = 1'b0;
  logic alarmClear = 1'b0;
  logic phaseAlarm;
  logic mainFs = 1'b0;
  logic mainMfs = 1'b0;
  logic auxFs = 1'b0;
  logic auxMfs = 1'b0;
  logic widthRef = 1'b0;
  logic frameSyncOutput;
  logic multiframeSyncOutput;
  logic genFrameSync;
  logic genMultiframeSync;
  // Bookkeeping
  int err_total = 0;
  int samples_checked = 0;
  int cycleCount = 0;
  // Short seconds keep the alarm scenarios brief
  pasp_top #(.CYCLES_PER_SEC(10)) i_pasp_top (
    .mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
    .pllInPreLockOrLost(pll), .alarmClear(alarmClear), .phaseAlarm(phaseAlarm),
    .mainFrameSync(mainFs), .mainMultiframeSync(mainMfs), .auxFrameSync(auxFs),
    .auxMultiframeSync(auxMfs), .widthReferenceOutput(widthRef),
    .frameSyncOutput(frameSyncOutput), .multiframeSyncOutput(multiframeSyncOutput),
    .genFrameSync(genFrameSync), .genMultiframeSync(genMultiframeSync)
  );
  // Free-running clock, 50 ns period
  initial
  begin
    forever #25 mclk = ~mclk;
  end
  // Verdict and end of run
  task automatic close_out();
    if (err_total == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  // Hang guard
  always @(posedge mclk)
  begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 6000)
    begin
      err_total = err_total + 1;
      close_out();
    end
  end
  // Compares one value against its expectation
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked = samples_checked + 1;
    if (seen !== exp)
    begin
      err_total = err_total + 1;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // Waits n falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask : cyc
  // One register write strobe
  task automatic reg_wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    cyc(1);
    regWrEn = 1'b0;
    cyc(1);
  endtask : reg_wr
  // One register read strobe, compared after the answer lands
  task automatic reg_rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    regAddr = a;
    regRdEn = 1'b1;
    cyc(1);
    regRdEn = 1'b0;
    check("regRdData", regRdData, exp);
    cyc(1);
  endtask : reg_rd
  // Reset values, masks of unused bits and unmapped addresses
  task automatic t_registers();
    reg_rd(ADDR_ALARM_DELAY, 8'h32);
    reg_rd(ADDR_SYNC_CFG, 8'h00);
    reg_rd(7'h7b, 8'h00);
    reg_wr(ADDR_ALARM_DELAY, 8'hff);
    reg_wr(ADDR_SYNC_CFG, 8'hff);
    reg_wr(7'h78, 8'hff);
    reg_rd(ADDR_ALARM_DELAY, 8'h3f);
    reg_rd(ADDR_SYNC_CFG, 8'h8f);
    reg_rd(7'h78, 8'h00);
  endtask : t_registers
  // Alarm after twice the field in seconds, held while the input is dropped
  task automatic t_alarm();
    reg_wr(ADDR_ALARM_DELAY, 8'h00);
    pll = 1'b1;
    cyc(3);
    check("phaseAlarm zero delay", phaseAlarm, 1'b1);
    pll = 1'b0;
    alarmClear = 1'b1;
    cyc(1);
    alarmClear = 1'b0;
    check("phaseAlarm cleared", phaseAlarm, 1'b0);
    reg_wr(ADDR_ALARM_DELAY, 8'h01);
    cyc(2);
    pll = 1'b1;
    cyc(21);
    check("phaseAlarm early", phaseAlarm, 1'b0);
    for (int i = 0; i < 4 && phaseAlarm !== 1'b1; i++)
      cyc(1);
    check("phaseAlarm two seconds", phaseAlarm, 1'b1);
    pll = 1'b0;
    cyc(5);
    check("phaseAlarm held", phaseAlarm, 1'b1);
    alarmClear = 1'b1;
    cyc(1);
    alarmClear = 1'b0;
    check("phaseAlarm released", phaseAlarm, 1'b0);
    // Alarm left standing releases itself after 128 short seconds
    reg_wr(ADDR_ALARM_DELAY, 8'h00);
    pll = 1'b1;
    cyc(3);
    pll = 1'b0;
    check("phaseAlarm raised again", phaseAlarm, 1'b1);
    cyc(1275);
    check("phaseAlarm before hold expiry", phaseAlarm, 1'b1);
    for (int i = 0; i < 10 && phaseAlarm !== 1'b0; i++)
      cyc(1);
    check("phaseAlarm hold expiry", phaseAlarm, 1'b0);
  endtask : t_alarm
  // Source select, polarity in 50:50 mode
  task automatic t_select();
    logic [1:0] outs;
    for (int c = 0; c < 4; c++)
    begin
      reg_wr(ADDR_SYNC_CFG, (c[0] ? 8'h80 : 8'h00) | (c[1] ? 8'h0a : 8'h00));
      mainFs = ~c[0];
      mainMfs = c[0];
      auxFs = c[0];
      auxMfs = ~c[0];
      cyc(3);
      check("genFrameSync", genFrameSync, 1'b1);
      check("genMultiframeSync", genMultiframeSync, 1'b0);
      outs = {frameSyncOutput, multiframeSyncOutput};
      check("sync outputs", outs, c[1] ? 2'b01 : 2'b10);
    end
    mainFs = 1'b0;
    mainMfs = 1'b0;
    auxFs = 1'b0;
    auxMfs = 1'b0;
  endtask : t_select
  // Pulsed mode: one width reference period, plain and inverted
  task automatic t_pulse(input logic [7:0] cfg, input logic act);
    int fsCount;
    int mfsCount;
    fsCount = 0;
    mfsCount = 0;
    reg_wr(ADDR_SYNC_CFG, cfg);
    cyc(4);
    mainFs = 1'b1;
    mainMfs = 1'b1;
    for (int i = 0; i < 24; i++)
    begin
      widthRef = (i % 4) >= 2;
      cyc(1);
      fsCount += (frameSyncOutput === act);
      mfsCount += (multiframeSyncOutput === act);
    end
    check("frame sync pulse width", 8'(fsCount), 8'h04);
    check("multiframe sync pulse width", 8'(mfsCount), 8'h04);
    mainFs = 1'b0;
    mainMfs = 1'b0;
    widthRef = 1'b0;
    cyc(4);
  endtask : t_pulse
  // Pulsed mode with the width reference idle gives no pulse
  task automatic t_noref();
    int n;
    n = 0;
    reg_wr(ADDR_SYNC_CFG, 8'h05);
    cyc(3);
    mainFs = 1'b1;
    for (int i = 0; i < 12; i++)
    begin
      cyc(1);
      n += (frameSyncOutput !== 1'b0);
    end
    check("frame sync without reference", 8'(n), 8'h00);
    mainFs = 1'b0;
  endtask : t_noref
  // Main sequence
  initial
  begin
    cyc(4);
    rst = 1'b0;
    t_registers();
    t_alarm();
    t_select();
    t_pulse(8'h05, 1'b1);
    t_pulse(8'h0f, 1'b0);
    t_noref();
    close_out();
  end
endmodule : tb_top
